// ### psr_cfg.svh
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// register map, byte addresses within the system control window
`define PSR_ADDR_W             12
`define PSR_WORD_LSB           2
`define PSR_OFS_SERIAL_TIMER   12'h044
`define PSR_OFS_PORTS          12'h048
`define PSR_RST_VAL            32'h0000_0000

// writable fields of each register, all other bits read zero
`define PSR_WMASK_SERIAL_TIMER 32'h0107_1037
`define PSR_WMASK_PORTS        32'h0000_00ff

// field positions, serial and timer register
`define PSR_BIT_CMP_ZERO       24
`define PSR_BIT_GPC_TWO        18
`define PSR_BIT_GPC_ONE        17
`define PSR_BIT_GPC_ZERO       16
`define PSR_BIT_TWI_ZERO       12
`define PSR_BIT_SYN_ONE        5
`define PSR_BIT_SYN_ZERO       4
`define PSR_BIT_ASY_TWO        2
`define PSR_BIT_ASY_ONE        1
`define PSR_BIT_ASY_ZERO       0

// field positions, port register
`define PSR_BIT_PORT_H         7
`define PSR_BIT_PORT_G         6
`define PSR_BIT_PORT_F         5
`define PSR_BIT_PORT_E         4
`define PSR_BIT_PORT_D         3
`define PSR_BIT_PORT_C         2
`define PSR_BIT_PORT_B         1
`define PSR_BIT_PORT_A         0

// bus response codes
`define PSR_RESP_OKAY          2'h0
`define PSR_RESP_SLVERR        2'h2

`endif

// ### psr_ctl.sv
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_ctl (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // write address channel
  input  wire logic [`PSR_ADDR_W-1:0]    awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  // write data channel
  input  wire psr_pkg::psr_word_t        wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // write response channel
  output psr_pkg::psr_resp_t             bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // read address channel
  input  wire logic [`PSR_ADDR_W-1:0]    araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  // read data channel
  output psr_pkg::psr_word_t             rdata,
  output psr_pkg::psr_resp_t             rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // capability registers of the system controller
  input  wire psr_pkg::psr_word_t        capability_mask_b,
  input  wire psr_pkg::psr_word_t        capability_mask_d,
  // serial and timer unit resets, high holds the unit in reset
  output logic                           comparator_zero_rst,
  output logic                           gp_counter_two_rst,
  output logic                           gp_counter_one_rst,
  output logic                           gp_counter_zero_rst,
  output logic                           two_wire_zero_rst,
  output logic                           sync_serial_one_rst,
  output logic                           sync_serial_zero_rst,
  output logic                           async_serial_two_rst,
  output logic                           async_serial_one_rst,
  output logic                           async_serial_zero_rst,
  // port resets, high holds the port in reset
  output logic                           port_h_rst,
  output logic                           port_g_rst,
  output logic                           port_f_rst,
  output logic                           port_e_rst,
  output logic                           port_d_rst,
  output logic                           port_c_rst,
  output logic                           port_b_rst,
  output logic                           port_a_rst
);
  // word decode, low address bits ignored
  function automatic psr_pkg::psr_sel_e decode_sel(
    input logic [`PSR_ADDR_W-1:0] addr
  );
    logic [`PSR_ADDR_W-1:0] ofs_serial;
    logic [`PSR_ADDR_W-1:0] ofs_ports;
    ofs_serial = `PSR_OFS_SERIAL_TIMER;
    ofs_ports  = `PSR_OFS_PORTS;
    if (addr[`PSR_ADDR_W-1:`PSR_WORD_LSB] ==
        ofs_serial[`PSR_ADDR_W-1:`PSR_WORD_LSB]) begin
      decode_sel = psr_pkg::PSR_SEL_SERIAL;
    end else if (addr[`PSR_ADDR_W-1:`PSR_WORD_LSB] ==
                 ofs_ports[`PSR_ADDR_W-1:`PSR_WORD_LSB]) begin
      decode_sel = psr_pkg::PSR_SEL_PORTS;
    end else begin
      decode_sel = psr_pkg::PSR_SEL_NONE;
    end
  endfunction

  logic                   aw_held_reg;
  logic                   aw_held_next;
  logic                   w_held_reg;
  logic                   w_held_next;
  logic [`PSR_ADDR_W-1:0] waddr_reg;
  logic [`PSR_ADDR_W-1:0] waddr_next;
  psr_pkg::psr_word_t     wdata_reg;
  psr_pkg::psr_word_t     wdata_next;
  logic [3:0]             wstrb_reg;
  logic [3:0]             wstrb_next;
  logic                   awready_reg;
  logic                   awready_next;
  logic                   wready_reg;
  logic                   wready_next;
  logic                   bvalid_reg;
  logic                   bvalid_next;
  psr_pkg::psr_resp_t     bresp_reg;
  psr_pkg::psr_resp_t     bresp_next;
  logic                   aw_take;
  logic                   w_take;
  logic                   do_write;
  psr_pkg::psr_sel_e      wr_sel;
  psr_pkg::psr_sel_e      rd_sel;
  logic                   wr_serial;
  logic                   wr_ports;
  psr_pkg::psr_word_t     serial_val;
  psr_pkg::psr_word_t     ports_val;

  // address and data may arrive in either order
  assign aw_take = awvalid & awready_reg;
  assign w_take  = wvalid & wready_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_sel = decode_sel(waddr_reg);
  assign rd_sel = decode_sel(araddr);
  assign wr_serial = do_write & (wr_sel == psr_pkg::PSR_SEL_SERIAL);
  assign wr_ports  = do_write & (wr_sel == psr_pkg::PSR_SEL_PORTS);

  assign aw_held_next = aw_take | (aw_held_reg & ~do_write);
  assign w_held_next  = w_take | (w_held_reg & ~do_write);
  assign waddr_next = aw_take ? awaddr : waddr_reg;
  assign wdata_next = w_take ? wdata : wdata_reg;
  assign wstrb_next = w_take ? wstrb : wstrb_reg;
  assign bvalid_next = do_write | (bvalid_reg & ~bready);
  // unmapped writes are dropped and answered with an error
  assign bresp_next = ~do_write ? bresp_reg :
                      (wr_sel == psr_pkg::PSR_SEL_NONE) ?
                      `PSR_RESP_SLVERR : `PSR_RESP_OKAY;
  // one write at a time: no new beat until the response is taken
  assign awready_next = ~aw_held_next & ~bvalid_next;
  assign wready_next  = ~w_held_next & ~bvalid_next;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= `PSR_RST_VAL;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PSR_RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  psr_mask_reg #(
    .WRITABLE (`PSR_WMASK_SERIAL_TIMER)
  ) u_serial_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (wr_serial),
    .wr_data  (wdata_reg),
    .wr_strb  (wstrb_reg),
    .cap_mask (capability_mask_b),
    .value    (serial_val)
  );

  psr_mask_reg #(
    .WRITABLE (`PSR_WMASK_PORTS)
  ) u_ports (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (wr_ports),
    .wr_data  (wdata_reg),
    .wr_strb  (wstrb_reg),
    .cap_mask (capability_mask_d),
    .value    (ports_val)
  );

  psr_rd_port u_rd (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .arvalid    (arvalid),
    .sel        (rd_sel),
    .arready    (arready),
    .serial_val (serial_val),
    .ports_val  (ports_val),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready)
  );

  // reset lines come straight from the register flops, no glitches
  assign comparator_zero_rst   = serial_val[`PSR_BIT_CMP_ZERO];
  assign gp_counter_two_rst    = serial_val[`PSR_BIT_GPC_TWO];
  assign gp_counter_one_rst    = serial_val[`PSR_BIT_GPC_ONE];
  assign gp_counter_zero_rst   = serial_val[`PSR_BIT_GPC_ZERO];
  assign two_wire_zero_rst     = serial_val[`PSR_BIT_TWI_ZERO];
  assign sync_serial_one_rst   = serial_val[`PSR_BIT_SYN_ONE];
  assign sync_serial_zero_rst  = serial_val[`PSR_BIT_SYN_ZERO];
  assign async_serial_two_rst  = serial_val[`PSR_BIT_ASY_TWO];
  assign async_serial_one_rst  = serial_val[`PSR_BIT_ASY_ONE];
  assign async_serial_zero_rst = serial_val[`PSR_BIT_ASY_ZERO];
  assign port_h_rst = ports_val[`PSR_BIT_PORT_H];
  assign port_g_rst = ports_val[`PSR_BIT_PORT_G];
  assign port_f_rst = ports_val[`PSR_BIT_PORT_F];
  assign port_e_rst = ports_val[`PSR_BIT_PORT_E];
  assign port_d_rst = ports_val[`PSR_BIT_PORT_D];
  assign port_c_rst = ports_val[`PSR_BIT_PORT_C];
  assign port_b_rst = ports_val[`PSR_BIT_PORT_B];
  assign port_a_rst = ports_val[`PSR_BIT_PORT_A];

  sequence s_wr_serial;
    wr_serial;
  endsequence

  sequence s_wr_ports;
    wr_ports;
  endsequence

  chk_masked_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_serial |=> ((serial_val ^ $past(serial_val)) &
                     ~$past(capability_mask_b)) == '0
  ) else $error("serial register bit changed without capability");

  chk_masked_ports: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_ports |=> ((ports_val ^ $past(ports_val)) &
                    ~$past(capability_mask_d)) == '0
  ) else $error("port register bit changed without capability");

  chk_reset_zero: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (serial_val == `PSR_RST_VAL) &&
                 (ports_val == `PSR_RST_VAL) && !bvalid && !rvalid
  ) else $error("registers not zero after reset");

  chk_comparator_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_serial ##0 (wstrb_reg[3] && wdata_reg[`PSR_BIT_CMP_ZERO] &&
                     capability_mask_b[`PSR_BIT_CMP_ZERO])
    |=> comparator_zero_rst
  ) else $error("comparator reset not set by bit 24");

  chk_timer_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_serial ##0 (wstrb_reg[2] && capability_mask_b[18:16] == 3'h7)
    |=> {gp_counter_two_rst, gp_counter_one_rst, gp_counter_zero_rst}
        == $past(wdata_reg[18:16])
  ) else $error("timer resets do not follow bits 18 to 16");

  chk_two_wire_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_serial ##0 (wstrb_reg[1] &&
                     capability_mask_b[`PSR_BIT_TWI_ZERO])
    |=> two_wire_zero_rst == $past(wdata_reg[`PSR_BIT_TWI_ZERO])
  ) else $error("two-wire reset does not follow bit 12");

  chk_serial_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_serial ##0 (wstrb_reg[0] && capability_mask_b[5:0] == 6'h37)
    |=> {sync_serial_one_rst, sync_serial_zero_rst, 1'b0,
         async_serial_two_rst, async_serial_one_rst,
         async_serial_zero_rst} == ($past(wdata_reg[5:0]) & 6'h37)
  ) else $error("serial unit resets do not follow bits 5 to 0");

  chk_port_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_ports ##0 (wstrb_reg[0] && capability_mask_d[7:0] == 8'hff)
    |=> {port_h_rst, port_g_rst, port_f_rst, port_e_rst, port_d_rst,
         port_c_rst, port_b_rst, port_a_rst} == $past(wdata_reg[7:0])
  ) else $error("port resets do not follow bits 7 to 0");

  chk_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((serial_val & ~`PSR_WMASK_SERIAL_TIMER) == '0) &&
    ((ports_val & ~`PSR_WMASK_PORTS) == '0)
  ) else $error("reserved bit read as one");

  chk_read_decode: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && rd_sel == psr_pkg::PSR_SEL_PORTS)
    |=> rvalid && rdata == $past(ports_val) && rresp == `PSR_RESP_OKAY
  ) else $error("read at port register offset returned wrong word");

  chk_release_unit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_ports ##0 (port_a_rst && wstrb_reg[0] &&
                    !wdata_reg[`PSR_BIT_PORT_A] &&
                    capability_mask_d[`PSR_BIT_PORT_A])
    |=> !port_a_rst
  ) else $error("port A not released after clearing its bit");

  // both beats in one edge, as a master offering them together does
  sequence s_both_beats;
    awvalid && awready && wvalid && wready;
  endsequence

  chk_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_both_beats |-> ##2 (bvalid && !awready && !wready)
  ) else $error("write response missing two cycles after beats");

  // no new write beat while the old response is unclaimed
  chk_write_single: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bvalid |-> !awready && !wready
  ) else $error("write beat accepted while response pending");

  chk_unmapped_drop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wr_sel == psr_pkg::PSR_SEL_NONE)
    |=> bvalid && bresp == `PSR_RESP_SLVERR &&
        $stable(serial_val) && $stable(ports_val)
  ) else $error("unmapped write changed a register");

  chk_read_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> rvalid && !arready
  ) else $error("read data missing one cycle after address");

  chk_read_error: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && rd_sel == psr_pkg::PSR_SEL_NONE)
    |=> rvalid && rdata == `PSR_RST_VAL && rresp == `PSR_RESP_SLVERR
  ) else $error("unmapped read not answered with error");

  // registers move only on a write decoded to them
  chk_serial_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !wr_serial |=> $stable(serial_val)
  ) else $error("serial register changed without a write");

  chk_ports_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !wr_ports |=> $stable(ports_val)
  ) else $error("port register changed without a write");
endmodule

// ### psr_ctl_tb.sv
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_ctl_tb;
  logic                  aclk;
  logic                  aresetn;
  logic [11:0]           awaddr;
  logic                  awvalid;
  logic                  awready;
  psr_pkg::psr_word_t    wdata;
  logic [3:0]            wstrb;
  logic                  wvalid;
  logic                  wready;
  psr_pkg::psr_resp_t    bresp;
  logic                  bvalid;
  logic                  bready;
  logic [11:0]           araddr;
  logic                  arvalid;
  logic                  arready;
  psr_pkg::psr_word_t    rdata;
  psr_pkg::psr_resp_t    rresp;
  logic                  rvalid;
  logic                  rready;
  psr_pkg::psr_word_t    cap_b;
  psr_pkg::psr_word_t    cap_d;
  wire [9:0]             rs;
  wire [7:0]             rp;
  psr_pkg::psr_word_t    out_serial;
  psr_pkg::psr_word_t    out_ports;
  int                    bad_count;
  int                    checks_done;

  psr_ctl i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capability_mask_b(cap_b), .capability_mask_d(cap_d),
    .comparator_zero_rst(rs[9]), .gp_counter_two_rst(rs[8]),
    .gp_counter_one_rst(rs[7]), .gp_counter_zero_rst(rs[6]),
    .two_wire_zero_rst(rs[5]), .sync_serial_one_rst(rs[4]),
    .sync_serial_zero_rst(rs[3]), .async_serial_two_rst(rs[2]),
    .async_serial_one_rst(rs[1]), .async_serial_zero_rst(rs[0]),
    .port_h_rst(rp[7]), .port_g_rst(rp[6]), .port_f_rst(rp[5]),
    .port_e_rst(rp[4]), .port_d_rst(rp[3]), .port_c_rst(rp[2]),
    .port_b_rst(rp[1]), .port_a_rst(rp[0])
  );

  // reset outputs placed where their register bits should be
  assign out_serial = {7'h00, rs[9], 5'h00, rs[8:6], 3'h0, rs[5],
                       6'h00, rs[4:3], 1'b0, rs[2:0]};
  assign out_ports  = {24'h00_0000, rp};

  always #20 aclk = ~aclk;

  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input psr_pkg::psr_word_t got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write with both channels offered together, bready held throughout
  task automatic wr(input logic [11:0] a, input psr_pkg::psr_word_t d,
                    input logic [3:0] s, input psr_pkg::psr_resp_t er);
    int n;
    logic got;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s;
    wvalid <= 1'b1; bready <= 1'b1;
    n = 0;
    got = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end while (!got && n < 50);
    bready <= 1'b0;
    if (!got) chk(32'h0000_0000, 32'hffff_ffff);
  endtask

  task automatic rd(input logic [11:0] a, input psr_pkg::psr_word_t ed,
                    input psr_pkg::psr_resp_t er);
    int n;
    logic got;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    got = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end while (!got && n < 50);
    rready <= 1'b0;
    if (!got) chk(32'h0000_0000, 32'hffff_ffff);
  endtask

  task automatic t_reset_values;
    chk(out_serial, `PSR_RST_VAL);
    chk(out_ports, `PSR_RST_VAL);
    rd(`PSR_OFS_SERIAL_TIMER, `PSR_RST_VAL, `PSR_RESP_OKAY);
    rd(`PSR_OFS_PORTS, `PSR_RST_VAL, `PSR_RESP_OKAY);
  endtask

  // walking one through every bit of both registers
  task automatic t_fields;
    psr_pkg::psr_word_t b;
    for (int i = 0; i < 32; i++) begin
      b = 32'h0000_0001 << i;
      wr(`PSR_OFS_SERIAL_TIMER, b, 4'hf, `PSR_RESP_OKAY);
      chk(out_serial, b & 32'h0107_1037);
      chk(out_serial, b & 32'h0107_1037);
      rd(`PSR_OFS_SERIAL_TIMER, b & 32'h0107_1037, `PSR_RESP_OKAY);
      wr(`PSR_OFS_PORTS, b, 4'hf, `PSR_RESP_OKAY);
      chk(out_ports, b & 32'h0000_00ff);
      rd(`PSR_OFS_PORTS, b & 32'h0000_00ff, `PSR_RESP_OKAY);
    end
  endtask

  task automatic t_cap_mask;
    wr(`PSR_OFS_SERIAL_TIMER, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
    wr(`PSR_OFS_PORTS, 32'hffff_ffff, 4'hf, `PSR_RESP_OKAY);
    cap_b <= 32'h0000_1005;
    cap_d <= 32'h0000_000f;
    wr(`PSR_OFS_SERIAL_TIMER, 32'h0000_0000, 4'hf, `PSR_RESP_OKAY);
    chk(out_serial, 32'h0107_0032);
    wr(`PSR_OFS_PORTS, 32'h0000_0000, 4'hf, `PSR_RESP_OKAY);
    chk(out_ports, 32'h0000_00f0);
    rd(`PSR_OFS_PORTS, 32'h0000_00f0, `PSR_RESP_OKAY);
    cap_b <= 32'hffff_ffff;
    cap_d <= 32'hffff_ffff;
    // only byte lane two enabled: timer resets clear, rest stays
    wr(`PSR_OFS_SERIAL_TIMER, 32'h0000_0000, 4'h4,
       `PSR_RESP_OKAY);
    chk(out_serial, 32'h0100_0032);
    // full write of 32'h0000_0032 clears the comparator bit, then read back
    wr(`PSR_OFS_SERIAL_TIMER, 32'h0000_0032, 4'hf, `PSR_RESP_OKAY);
    rd(`PSR_OFS_SERIAL_TIMER, 32'h0000_0032, `PSR_RESP_OKAY);
  endtask

  // neighbours of the map must not alias onto either register
  task automatic t_unmapped;
    wr(12'h040, 32'hffff_ffff, 4'hf, `PSR_RESP_SLVERR);
    wr(12'h04c, 32'hffff_ffff, 4'hf, `PSR_RESP_SLVERR);
    rd(12'h04c, 32'h0000_0000, `PSR_RESP_SLVERR);
    rd(`PSR_OFS_SERIAL_TIMER, 32'h0000_0032, `PSR_RESP_OKAY);
    rd(`PSR_OFS_PORTS, 32'h0000_00f0, `PSR_RESP_OKAY);
    chk(out_ports, 32'h0000_00f0);
  endtask

  task automatic t_release;
    wr(`PSR_OFS_PORTS, 32'h0000_0000, 4'hf, `PSR_RESP_OKAY);
    chk(out_ports, 32'h0000_0000);
  endtask

  task automatic t_mid_reset;
    wr(`PSR_OFS_PORTS, 32'h0000_00a5, 4'hf, `PSR_RESP_OKAY);
    chk(out_ports, 32'h0000_00a5);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(out_serial, `PSR_RST_VAL);
    chk(out_ports, `PSR_RST_VAL);
    rd(`PSR_OFS_PORTS, `PSR_RST_VAL, `PSR_RESP_OKAY);
  endtask

  // a run needs well under 2000 cycles
  initial begin
    #(40 * 5000);
    bad_count++;
    end_of_test;
  end

  initial begin
    aclk = 1'b0;
    bad_count = 0;
    checks_done = 0;
    aresetn <= 1'b0;
    awaddr <= 12'h000; awvalid <= 1'b0; wdata <= 32'h0000_0000;
    wstrb <= 4'h0; wvalid <= 1'b0; bready <= 1'b0;
    araddr <= 12'h000; arvalid <= 1'b0; rready <= 1'b0;
    cap_b <= 32'hffff_ffff;
    cap_d <= 32'hffff_ffff;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values;
    t_fields;
    t_cap_mask;
    t_unmapped;
    t_release;
    t_mid_reset;
    end_of_test;
  end
endmodule

// ### psr_mask_reg.sv
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_mask_reg #(
  parameter logic [31:0] WRITABLE = `PSR_WMASK_PORTS
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // write strobe with data
  input  wire logic               wr_en,
  input  wire psr_pkg::psr_word_t wr_data,
  input  wire logic [3:0]         wr_strb,
  // capability bits of present units
  input  wire psr_pkg::psr_word_t cap_mask,
  // stored value
  output psr_pkg::psr_word_t      value
);
  psr_pkg::psr_word_t value_reg;
  psr_pkg::psr_word_t value_next;
  psr_pkg::psr_word_t lane_mask;
  psr_pkg::psr_word_t bit_mask;

  assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // absent units and reserved bits never take a write
  assign bit_mask = lane_mask & cap_mask & WRITABLE;
  assign value_next = wr_en ? ((value_reg & ~bit_mask) |
                               (wr_data & bit_mask)) : value_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_reg <= `PSR_RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule

// ### psr_pkg.sv
package psr_pkg;
  typedef logic [31:0] psr_word_t;
  typedef logic [1:0]  psr_resp_t;
  typedef enum logic [1:0] {
    PSR_SEL_NONE,
    PSR_SEL_SERIAL,
    PSR_SEL_PORTS
  } psr_sel_e;
endpackage

// ### psr_rd_port.sv
`timescale 1ns/1ps
`include "psr_cfg.svh"

module psr_rd_port (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // read address, already decoded
  input  wire logic               arvalid,
  input  wire psr_pkg::psr_sel_e  sel,
  output logic                    arready,
  // register values
  input  wire psr_pkg::psr_word_t serial_val,
  input  wire psr_pkg::psr_word_t ports_val,
  // read data channel
  output psr_pkg::psr_word_t      rdata,
  output psr_pkg::psr_resp_t      rresp,
  output logic                    rvalid,
  input  wire logic               rready
);
  logic               arready_reg;
  logic               arready_next;
  logic               rvalid_reg;
  logic               rvalid_next;
  psr_pkg::psr_word_t rdata_reg;
  psr_pkg::psr_word_t rdata_next;
  psr_pkg::psr_resp_t rresp_reg;
  psr_pkg::psr_resp_t rresp_next;
  logic               ar_take;

  assign ar_take = arvalid & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~rready);
  // one read in flight; the address waits while data are unclaimed
  assign arready_next = ~rvalid_next;

  always_comb begin
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      unique case (sel)
        psr_pkg::PSR_SEL_SERIAL: begin
          rdata_next = serial_val;
          rresp_next = `PSR_RESP_OKAY;
        end
        psr_pkg::PSR_SEL_PORTS: begin
          rdata_next = ports_val;
          rresp_next = `PSR_RESP_OKAY;
        end
        psr_pkg::PSR_SEL_NONE: begin
          rdata_next = `PSR_RST_VAL;
          rresp_next = `PSR_RESP_SLVERR;
        end
        default: begin
          rdata_next = `PSR_RST_VAL;
          rresp_next = `PSR_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `PSR_RST_VAL;
      rresp_reg   <= `PSR_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
endmodule
